// ==== rtl/dpmc_cfg.svh ====
/*
  Register indices, field positions, reset values and timing counts for the
  loop mode-control register bank.
  Assumes it is included by bare name after the package and before use.
*/
`ifndef DPMC_CFG_SVH
`define DPMC_CFG_SVH

// ----------------------------------------
// Register indices on the processor port
// ----------------------------------------
`define DPMC_IDX_REF_CFG 2'h0
`define DPMC_IDX_MODE 2'h1
`define DPMC_IDX_DEC 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPMC_REF_CFG_RST 8'h00
`define DPMC_MODE_RST 8'h81
`define DPMC_DEC_RST 8'h36
`define DPMC_SHIFT_RST 4'h6

// ----------------------------------------
// Field masks and codes
// ----------------------------------------
`define DPMC_REF_CFG_WMASK 8'hD3
`define DPMC_DEC_WMASK 8'h7F
`define DPMC_SEL_MANUAL 2'h0
`define DPMC_SEL_AUTO 2'h2
`define DPMC_MODE_FREERUN 2'h0
`define DPMC_MODE_AUTO 2'h1
`define DPMC_MODE_HOLDOVER 2'h2
`define DPMC_MODE_WRFREQ 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define DPMC_MEASURE_NS 80
`define DPMC_CLK_PERIOD_NS 5
`define DPMC_MEASURE_CYCLES (`DPMC_MEASURE_NS / `DPMC_CLK_PERIOD_NS)

`endif

// ==== rtl/dpmc_pkg.sv ====
/*
  Types of the loop mode-control register bank: register layouts and the
  loop state enumeration.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpmc_pkg;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sel_mode;
    logic rsv5;
    logic manual_sel;
    logic [1:0] rsv3_2;
    logic revertive_en;
    logic hitless_en;
  } dpmc_ref_cfg_t;

  typedef struct packed {
    logic auto_acquire_filter_switch;
    logic ref_loss_goes_freerun;
    logic [1:0] rsv5_4;
    logic filter_update_dis;
    logic loop_en;
    logic [1:0] mode;
  } dpmc_mode_ctl_t;

  typedef struct packed {
    logic rsv7;
    logic [2:0] switch_decimator_shift;
    logic [3:0] main_decimator_shift;
  } dpmc_dec_cfg_t;

  // ----------------------------------------
  // Loop state
  // ----------------------------------------
  typedef enum logic [2:0] {
    DPMC_ST_FREERUN,
    DPMC_ST_ACQUIRE,
    DPMC_ST_NORMAL,
    DPMC_ST_HOLDOVER,
    DPMC_ST_WRFREQ
  } dpmc_state_t;

endpackage

// ==== rtl/dpmc_loop_fsm.sv ====
/*
  Loop state machine: forced and automatic modes, acquire/normal, and the
  reaction to loss of the selected reference.
  Assumes reference validity and lock come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpmc_cfg.svh"

module dpmc_loop_fsm
  import dpmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic [1:0] mode,
  input wire logic loop_en,
  input wire logic ref_loss_goes_freerun,
  // Loop status
  input wire logic ref_valid,
  input wire logic locked,
  // State
  output dpmc_state_t state,
  output logic holdover_exit
);

  dpmc_state_t state_q;
  dpmc_state_t state_d;
  dpmc_state_t loss_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    // [R6] loss destination
    loss_st = ref_loss_goes_freerun ? DPMC_ST_FREERUN : DPMC_ST_HOLDOVER;
    state_d = state_q;
    // [R10] forced modes
    case (mode)
      `DPMC_MODE_FREERUN: state_d = DPMC_ST_FREERUN;
      `DPMC_MODE_HOLDOVER: state_d = DPMC_ST_HOLDOVER;
      `DPMC_MODE_WRFREQ: state_d = DPMC_ST_WRFREQ;
      default:
      begin
        // Automatic tracking needs the full loop running
        if (!loop_en)
        begin
          state_d = DPMC_ST_FREERUN;
        end
        else
        begin
          case (state_q)
            DPMC_ST_ACQUIRE: state_d = !ref_valid ? loss_st
                                     : (locked ? DPMC_ST_NORMAL : DPMC_ST_ACQUIRE);
            DPMC_ST_NORMAL: state_d = !ref_valid ? loss_st : DPMC_ST_NORMAL;
            default: state_d = ref_valid ? DPMC_ST_ACQUIRE : state_q;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= DPMC_ST_FREERUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign state = state_q;
  assign holdover_exit = (state_q == DPMC_ST_HOLDOVER) && (state_d == DPMC_ST_ACQUIRE);

endmodule
`default_nettype wire

// ==== rtl/dpmc_top.sv ====
/*
  Digital loop mode-control register bank with reference selection,
  filter-update control and decimator bandwidth outputs.
  Assumes the processor port and the reference monitors are on clock.
*/
// Behaviour
// [R1] Selection mode 0 is manual by select bit, 2 is automatic; resets manual.
// [R2] Manual select bit picks clock input zero when clear, one when set.
// [R3] Revertive bit makes automatic switching revertive; resets non-revertive.
// [R4] Hitless bit enables hitless switches; resets disabled.
// [R5] Auto switch bit selects acquire filter settings in Acquire; resets one.
// [R6] Losing the reference enters Holdover, or Freerun when the loss bit set.
// [R7] Software freezes filter update around loop reconfiguration while enabled.
// [R8] Write-frequency writes need no freeze and suppress the filter update.
// [R9] Loop enable zero gates all but filter and scaler; one runs everything.
// [R10] Mode field: 0 Freerun, 1 automatic, 2 Holdover, 3 write frequency.
// [R11] Switch decimator shift, reset 3, used while measuring; ignored unless hitless.
// [R12] Main decimator shift, reset 6; zero passes samples straight through.
// [R13] Read-only reserved bits read zero; writable reserved bits just store.
`timescale 1ns/1ps
`default_nettype none
`include "dpmc_cfg.svh"

module dpmc_top
  import dpmc_pkg::*;
#(
  parameter int MEASURE_CYCLES = `DPMC_MEASURE_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Processor port
  input wire logic [1:0] reg_idx,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic wfreq_wr,
  // Reference monitors and lock
  input wire logic clock_input_zero_valid,
  input wire logic clock_input_one_valid,
  input wire logic locked,
  // Loop controls
  output logic ref_sel,
  output logic ref_switch,
  output logic filter_update_en,
  output logic use_acquire_filter,
  output logic loop_core_clk_en,
  output logic filter_scaler_clk_en,
  output logic hitless_switch,
  output logic revertive,
  output logic [3:0] decimator_shift,
  output logic decimator_bypass,
  output dpmc_state_t loop_state
);

  dpmc_ref_cfg_t ref_q;
  dpmc_ref_cfg_t ref_d;
  dpmc_mode_ctl_t mode_q;
  dpmc_mode_ctl_t mode_d;
  dpmc_dec_cfg_t dec_q;
  dpmc_dec_cfg_t dec_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic cur_q;
  logic cur_d;
  logic [1:0] valid;
  logic holdover_exit;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic fu_q;
  logic fu_d;
  logic acq_q;
  logic acq_d;
  logic [3:0] shift_q;
  logic [3:0] shift_d;
  logic byp_q;
  logic byp_d;

  function automatic logic hit(input logic [1:0] idx, input logic [1:0] want);
    hit = (idx == want);
  endfunction

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  always_comb
  begin
    ref_d = ref_q;
    mode_d = mode_q;
    dec_d = dec_q;
    // [R13] reserved read-only bits masked
    if (reg_wr && hit(reg_idx, `DPMC_IDX_REF_CFG))
    begin
      ref_d = reg_wdata & `DPMC_REF_CFG_WMASK;
    end
    if (reg_wr && hit(reg_idx, `DPMC_IDX_MODE))
    begin
      mode_d = reg_wdata;
    end
    if (reg_wr && hit(reg_idx, `DPMC_IDX_DEC))
    begin
      dec_d = reg_wdata & `DPMC_DEC_WMASK;
    end
    case (reg_idx)
      `DPMC_IDX_REF_CFG: rdata_d = ref_q;
      `DPMC_IDX_MODE: rdata_d = mode_q;
      `DPMC_IDX_DEC: rdata_d = dec_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ref_q <= `DPMC_REF_CFG_RST;
      mode_q <= `DPMC_MODE_RST;
      dec_q <= `DPMC_DEC_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      ref_q <= ref_d;
      mode_q <= mode_d;
      dec_q <= dec_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Reference selection
  // ----------------------------------------
  assign valid = {clock_input_one_valid, clock_input_zero_valid};

  always_comb
  begin
    cur_d = cur_q;
    // [R1] manual or automatic
    if (ref_q.sel_mode == `DPMC_SEL_AUTO)
    begin
      if (!valid[cur_q] && valid[~cur_q])
      begin
        cur_d = ~cur_q;
      end
      // [R3] revert to input zero
      else if (ref_q.revertive_en && cur_q && valid[0])
      begin
        cur_d = 1'b0;
      end
    end
    else if (ref_q.sel_mode == `DPMC_SEL_MANUAL)
    begin
      // [R2] manual pick
      cur_d = ref_q.manual_sel;
    end
  end

  dpmc_loop_fsm u_fsm (
    .clock(clock),
    .rst(rst),
    .mode(mode_q.mode),
    .loop_en(mode_q.loop_en),
    .ref_loss_goes_freerun(mode_q.ref_loss_goes_freerun),
    .ref_valid(valid[cur_q]),
    .locked(locked),
    .state(loop_state),
    .holdover_exit(holdover_exit)
  );

  // ----------------------------------------
  // Loop controls
  // ----------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    // [R4] measurement window only when hitless
    if (!ref_q.hitless_en)
    begin
      cnt_d = 8'h00;
    end
    else if ((cur_d != cur_q) || holdover_exit)
    begin
      cnt_d = 8'(MEASURE_CYCLES);
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_d = cnt_q - 8'h01;
    end
    // [R7] software freeze
    // [R8] write-frequency suppresses the update
    fu_d = !(mode_q.filter_update_dis || wfreq_wr);
    // [R5] acquire filter settings
    acq_d = mode_q.auto_acquire_filter_switch && (loop_state == DPMC_ST_ACQUIRE);
    // [R11] switch shift while measuring
    // A window left over when hitless is cleared must not leak through
    if (ref_q.hitless_en && (cnt_q != 8'h00))
    begin
      shift_d = {1'b0, dec_q.switch_decimator_shift};
    end
    else
    begin
      shift_d = dec_q.main_decimator_shift;
    end
    // [R12] zero shift is feed-through
    byp_d = (shift_d == 4'h0);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur_q <= 1'b0;
      cnt_q <= 8'h00;
      fu_q <= 1'b1;
      acq_q <= 1'b0;
      shift_q <= `DPMC_SHIFT_RST;
      byp_q <= 1'b0;
    end
    else
    begin
      cur_q <= cur_d;
      cnt_q <= cnt_d;
      fu_q <= fu_d;
      acq_q <= acq_d;
      shift_q <= shift_d;
      byp_q <= byp_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign ref_sel = cur_q;
  assign ref_switch = (cur_d != cur_q);
  assign hitless_switch = ref_switch && ref_q.hitless_en;
  assign revertive = ref_q.revertive_en;
  assign filter_update_en = fu_q;
  assign use_acquire_filter = acq_q;
  // [R9] core gated, filter and scaler always clocked
  assign loop_core_clk_en = mode_q.loop_en;
  assign filter_scaler_clk_en = 1'b1;
  assign decimator_shift = shift_q;
  assign decimator_bypass = byp_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_mode_reset_val: assert property ($past(rst) |-> // [R10]
      mode_q == `DPMC_MODE_RST && dec_q == `DPMC_DEC_RST && ref_q == `DPMC_REF_CFG_RST)
    else $error("reset values wrong");
  a_manual_ref_pick: assert property (ref_q.sel_mode == 2'h0 |=> // [R2]
      cur_q == $past(ref_q.manual_sel))
    else $error("manual selection not followed");
  a_auto_fail_over: assert property (ref_q.sel_mode == 2'h2 && !valid[cur_q] && // [R1]
      valid[~cur_q] |=> cur_q != $past(cur_q))
    else $error("automatic failover missing");
  a_revert_to_zero: assert property (ref_q.sel_mode == 2'h2 && ref_q.revertive_en && // [R3]
      cur_q && valid == 2'b11 |=> !cur_q)
    else $error("revertive switch missing");
  a_nonrevert_stay: assert property (ref_q.sel_mode == 2'h2 && !ref_q.revertive_en && // [R3]
      cur_q && valid[1] |=> cur_q)
    else $error("non-revertive moved");
  a_loss_to_target: assert property (mode_q.mode == 2'h1 && mode_q.loop_en && // [R6]
      loop_state == DPMC_ST_NORMAL && !valid[cur_q] |=>
      loop_state == ($past(mode_q.ref_loss_goes_freerun) ? DPMC_ST_FREERUN : DPMC_ST_HOLDOVER))
    else $error("wrong state on reference loss");
  a_forced_mode: assert property (mode_q.mode == 2'h2 ##1 mode_q.mode == 2'h2 |-> // [R10]
      loop_state == DPMC_ST_HOLDOVER)
    else $error("forced holdover ignored");
  a_acquire_filter: assert property (mode_q.auto_acquire_filter_switch && // [R5]
      loop_state == DPMC_ST_ACQUIRE |=> use_acquire_filter)
    else $error("acquire settings not used");
  a_wfreq_suppress: assert property (wfreq_wr |=> !filter_update_en) // [R8]
    else $error("write frequency did not suppress update");
  a_hitless_ignored: assert property (!ref_q.hitless_en |=> // [R11]
      decimator_shift == $past(dec_q.main_decimator_shift))
    else $error("switch shift used without hitless");
  a_dec_bypass: assert property (!ref_q.hitless_en |=> // [R12]
      decimator_bypass == ($past(dec_q.main_decimator_shift) == 4'h0))
    else $error("bypass disagrees with main shift");
  a_rsv_read_zero: assert property ($past(reg_idx) == 2'h0 |-> (reg_rdata & 8'h2C) == 8'h00) // [R13]
    else $error("reserved bits read non-zero");

  c_ref_switch: cover property (ref_switch && ref_q.sel_mode == 2'h2);
  c_acquire_to_normal: cover property (loop_state == DPMC_ST_ACQUIRE ##1 loop_state == DPMC_ST_NORMAL);
  c_holdover_exit: cover property (holdover_exit && ref_q.hitless_en);

endmodule
`default_nettype wire

// ==== verif/tb.sv ====
/*
  Self-checking bench for the loop mode-control register bank.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import dpmc_pkg::*;
();
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_idx = 2'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic wfreq_wr = 1'b0;
  logic v0 = 1'b1;
  logic v1 = 1'b1;
  logic locked = 1'b0;
  logic [7:0] reg_rdata, r, d;
  logic ref_sel, ref_switch, filter_update_en, use_acquire_filter, hs, s3, sw;
  logic loop_core_clk_en, filter_scaler_clk_en, hitless_switch, revertive;
  logic [3:0] decimator_shift;
  logic decimator_bypass;
  dpmc_state_t loop_state;
  logic [1:0] x;
  int seed;
  int err_count = 0;
  int n_compared = 0;

  // Short window keeps the hitless scan to a few cycles
  dpmc_top #(.MEASURE_CYCLES(2)) i_dpmc_top (
    .clock(clock), .rst(rst), .reg_idx(reg_idx), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wfreq_wr(wfreq_wr),
    .clock_input_zero_valid(v0), .clock_input_one_valid(v1), .locked(locked),
    .ref_sel(ref_sel), .ref_switch(ref_switch), .filter_update_en(filter_update_en),
    .use_acquire_filter(use_acquire_filter), .loop_core_clk_en(loop_core_clk_en),
    .filter_scaler_clk_en(filter_scaler_clk_en), .hitless_switch(hitless_switch),
    .revertive(revertive), .decimator_shift(decimator_shift),
    .decimator_bypass(decimator_bypass), .loop_state(loop_state)
  );

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [7:0] rst_val(input logic [1:0] i);
    return (i == 2'h0) ? 8'h00 : (i == 2'h1) ? 8'h81 : (i == 2'h2) ? 8'h36 : 8'h00;
  endfunction

  // Read-only reserved bits and the unmapped index never store
  function automatic logic [7:0] wmask(input logic [1:0] i);
    return (i == 2'h0) ? 8'hD3 : (i == 2'h1) ? 8'hFF : (i == 2'h2) ? 8'h7F : 8'h00;
  endfunction

  // ----------------------------------------
  // Port tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [1:0] i, input logic [7:0] v);
    reg_idx = i;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(2);
  endtask

  task automatic rd(input logic [1:0] i, output logic [7:0] v);
    reg_idx = i;
    cyc(1);
    v = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    close_out();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    seed = 57;
    cyc(4);
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(2'(i), r);
      chk("reset reg", rst_val(2'(i)), r); // reset contents
    end
    chk("dec shift", 8'h06, {4'h0, decimator_shift}); // reset shift
    chk("core clk", 8'h00, {7'h0, loop_core_clk_en}); // gated after reset
    for (int i = 0; i < 20; i++)
    begin
      x = (i < 4) ? 2'(i) : 2'($random(seed));
      d = (i < 4) ? 8'hFF : 8'($random(seed));
      wr(x, d);
      rd(x, r);
      chk("readback", wmask(x) & d, r); // reserved bits
    end
    wr(0, 8'h10);
    chk("ref sel", 8'h01, {7'h0, ref_sel}); // manual input one
    chk("revertive", 8'h00, {7'h0, revertive}); // non-revertive
    wr(0, 8'h02);
    chk("ref sel", 8'h00, {7'h0, ref_sel}); // manual input zero
    chk("revertive", 8'h01, {7'h0, revertive}); // revertive level
    wr(2, 8'h36);
    wr(1, 8'h84);
    chk("state", 8'(DPMC_ST_FREERUN), 8'(loop_state)); // forced freerun
    chk("core clk", 8'h01, {7'h0, loop_core_clk_en}); // full loop runs
    wr(1, 8'h86);
    chk("state", 8'(DPMC_ST_HOLDOVER), 8'(loop_state)); // forced holdover
    wr(1, 8'h87);
    chk("state", 8'(DPMC_ST_WRFREQ), 8'(loop_state)); // write frequency
    wr(1, 8'h85);
    chk("state", 8'(DPMC_ST_ACQUIRE), 8'(loop_state)); // automatic acquire
    chk("acq filter", 8'h01, {7'h0, use_acquire_filter}); // acquire settings
    wr(1, 8'h05);
    chk("acq filter", 8'h00, {7'h0, use_acquire_filter}); // normal settings always
    locked = 1'b1;
    cyc(2);
    chk("state", 8'(DPMC_ST_NORMAL), 8'(loop_state)); // locked normal
    v0 = 1'b0;
    cyc(2);
    chk("state", 8'(DPMC_ST_HOLDOVER), 8'(loop_state)); // loss to holdover
    v0 = 1'b1;
    cyc(3);
    wr(1, 8'h45);
    v0 = 1'b0;
    cyc(2);
    chk("state", 8'(DPMC_ST_FREERUN), 8'(loop_state)); // loss to freerun
    v0 = 1'b1;
    wr(1, 8'h05);
    wfreq_wr = 1'b1;
    cyc(1);
    wfreq_wr = 1'b0;
    chk("filt upd", 8'h00, {7'h0, filter_update_en}); // write suppresses update
    cyc(2);
    chk("filt upd", 8'h01, {7'h0, filter_update_en}); // update resumes
    wr(1, 8'h0D);
    chk("filt upd", 8'h00, {7'h0, filter_update_en}); // freeze bit
    wr(1, 8'h01);
    chk("core clk", 8'h00, {7'h0, loop_core_clk_en}); // loop gated
    chk("scaler clk", 8'h01, {7'h0, filter_scaler_clk_en}); // filter keeps clock
    wr(2, 8'h30);
    chk("bypass", 8'h01, {7'h0, decimator_bypass}); // zero feeds through
    wr(2, 8'h75);
    chk("dec shift", 8'h05, {4'h0, decimator_shift}); // switch shift ignored
    chk("bypass", 8'h00, {7'h0, decimator_bypass}); // filtered again
    wr(2, 8'h36);
    wr(1, 8'h85);
    for (int h = 0; h < 2; h++)
    begin
      wr(1, 8'h8D);
      chk("filt upd", 8'h00, {7'h0, filter_update_en}); // frozen while reconfiguring
      wr(0, 8'h82 | 8'(h));
      wr(1, 8'h85);
      cyc(4);
      chk("ref sel", 8'h00, {7'h0, ref_sel}); // back on input zero
      v0 = 1'b0;
      hs = 1'b0;
      sw = 1'b0;
      s3 = 1'b0;
      repeat (8)
      begin
        // Switch strobes stand only in the cycle before the edge
        #1;
        hs |= hitless_switch;
        sw |= ref_switch;
        s3 |= (decimator_shift === 4'h3);
        cyc(1);
      end
      chk("hitless", 8'(h), {7'h0, hs}); // hitless switch gating
      chk("ref switch", 8'h01, {7'h0, sw}); // switch strobe seen
      chk("switch shift", 8'(h), {7'h0, s3}); // measuring window shift
      chk("ref sel", 8'h01, {7'h0, ref_sel}); // automatic switch
      v0 = 1'b1;
      cyc(4);
    end
    wr(0, 8'h80);
    v0 = 1'b0;
    cyc(4);
    v0 = 1'b1;
    cyc(4);
    chk("ref sel", 8'h01, {7'h0, ref_sel}); // stays without revert
    close_out();
  end

endmodule

`default_nettype wire
